// ---- scr_pkg.sv ----
// shared constants and types of the scsi status and setup register bank
package scr_pkg;
    localparam int AXI_AW = 18;
    localparam int AXI_DW = 32;
    // register indices, byte address is four times the index
    localparam logic [15:0] IDX_STAT = 16'hf0ac;
    localparam logic [15:0] IDX_CAUSE = 16'hf0ad;
    localparam logic [15:0] IDX_STEP = 16'hf0ae;
    localparam logic [15:0] IDX_LEVEL = 16'hf0af;
    localparam logic [15:0] IDX_SETUP1 = 16'hf0b4;
    localparam logic [15:0] IDX_CLOCK = 16'hf0b5;
    localparam logic [15:0] IDX_SETUP2 = 16'hf0b7;
    localparam logic [15:0] IDX_SETUP3 = 16'hf0bc;
    localparam logic [15:0] IDX_SETUP4 = 16'hf0bd;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // sticky flag bank layout: cause bits 0..7, status flags above
    localparam int NFLAG = 12;
    localparam int C_SEL = 0;
    localparam int C_CHOSEN_WITH_ATTENTION = 1;
    localparam int C_RECHOSEN_AS_INITIATOR = 2;
    localparam int C_FC = 3;
    localparam int C_BS = 4;
    localparam int C_DIS = 5;
    localparam int C_BAD_OPCODE = 6;
    localparam int C_BUS_RESET_SEEN = 7;
    localparam int F_VGC = 8;
    localparam int F_TC = 9;
    localparam int F_PE = 10;
    localparam int F_GE = 11;
    // setup bit positions
    localparam int S1_PARITY_CHECK_ON = 4;
    localparam int S1_SRD = 6;
    localparam int S3_TEN_BYTE_GROUP_TWO = 5;
    // command group codes
    localparam logic [2:0] GRP_SIX = 3'h0;
    localparam logic [2:0] GRP_TEN = 3'h1;
    localparam logic [2:0] GRP_TEN_TWO = 3'h2;
    localparam logic [2:0] GRP_TWELVE = 3'h5;
    // synchronised pins
    localparam int NPIN = 5;
    localparam int P_IO = 0;
    localparam int P_CD = 1;
    localparam int P_MSG = 2;
    localparam int P_ATN = 3;
    localparam int P_RST = 4;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [4:0] PERIOD_MAX = 5'h1f;
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_ADDR = 2'b01,
        WR_DATA = 2'b10,
        WR_RESP = 2'b11
    } scr_wr_t;
endpackage : scr_pkg

// ---- scr_flag_if.sv ----
// carrier between the register top and its sticky flag bank
`timescale 1ns/100ps
interface scr_flag_if;
    import scr_pkg::*;
    logic [NFLAG-1:0] set;
    logic [NFLAG-1:0] clr;
    logic [NFLAG-1:0] flags;
    modport bank (input set, input clr, output flags);
    modport user (output set, output clr, input flags);
endinterface : scr_flag_if

// ---- scr_flag_bank.sv ----
// sticky event flags, set wins over clear
`timescale 1ns/100ps
module scr_flag_bank import scr_pkg::*; (
    input wire logic sys_clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic ce, // clock enable
    scr_flag_if.bank fl // set, clear and flag vectors
);
    logic [NFLAG-1:0] flags_q;

    genvar gi;
    generate
        for (gi = 0; gi < NFLAG; gi++) begin : g_flag
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    flags_q[gi] <= 1'b0;
                end else if (ce) begin
                    // an event in the clearing cycle must survive
                    flags_q[gi] <= fl.set[gi] | (flags_q[gi] & ~fl.clr[gi]);
                end
            end
        end
    endgenerate

    assign fl.flags = flags_q;

    property p_set_wins;
        @(posedge sys_clk) disable iff (rst)
        (ce && fl.set != '0) |=> ((fl.flags & $past(fl.set)) == $past(fl.set));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set event lost");

endmodule : scr_flag_bank

// ---- scr_regs.sv ----
// scsi controller status, cause, step, level and setup registers on axi4-lite
//
// Summary of operation
// R1: count_expired flag sets when the transfer counter reaches zero.
// R2: parity_fault flag sets only on a bus parity error with checking enabled.
// R3: gross_fault flag sets on error conditions and never raises an interrupt alone.
// R4: irq pending bit shows whether an interrupt is being requested.
// R5: three status bits mirror the msg, c/d and i/o bus lines.
// R6: valid_group flag sets when a received command group code is a standard one.
// R7: selection sets chosen-as-target without atn, chosen_with_attention with atn.
// R8: rechosen_as_initiator sets when reselected while acting as initiator.
// R9: function_done sets after any command completes in target mode.
// R10: bus_service sets on service request, and on every atn rise in target mode.
// R11: link_dropped sets in target mode when a sequence command disconnects.
// R12: bad_opcode sets on a reserved opcode or one invalid for the mode group.
// R13: bus_reset_seen sets when a reset is seen on the scsi bus.
// R14: cause address write loads selection timeout; read returns the cause bits.
// R15: three-bit step_counter advances within a command and is readable.
// R16: offset_not_full clears when the sync offset is at its maximum.
// R17: five-bit sync_period sets the least gap between req or ack pulses.
// R18: level read gives fifo_fill_level low and step_counter copy high.
// R19: level address write loads the eight-bit sync_window offset.
// R20: bus_reset_irq_mask keeps a bus reset from raising the interrupt.
// R21: ten_byte_group_two setting lets group-two commands count as recognised.
// R22: software programs the write-only clock_factor_value before bus use.
`timescale 1ns/100ps
module scr_regs import scr_pkg::*; (
    input wire logic sys_clk, // 20 MHz system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic [AXI_AW-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [AXI_DW-1:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [AXI_AW-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [AXI_DW-1:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic scsi_msg, // bus msg line, asynchronous
    input wire logic scsi_cd, // bus c/d line, asynchronous
    input wire logic scsi_io, // bus i/o line, asynchronous
    input wire logic scsi_atn, // bus atn line, asynchronous
    input wire logic scsi_rst, // bus reset line, asynchronous
    input wire logic target_mode, // core acts as target
    input wire logic ev_count_zero, // transfer counter reached zero
    input wire logic ev_parity_err, // parity error seen on bus
    input wire logic ev_gross_err, // gross error condition
    input wire logic cdb_valid, // command group code received
    input wire logic [2:0] cdb_group, // received group code
    input wire logic ev_selected, // selected as a target
    input wire logic ev_rechosen_as_initiator, // reselected
    input wire logic ev_cmd_done, // command completed
    input wire logic ev_service_req, // other device wants service
    input wire logic ev_seq_disc, // sequence command disconnected
    input wire logic opcode_wr, // opcode written to command register
    input wire logic opcode_reserved, // written opcode is reserved
    input wire logic opcode_mode_bad, // opcode invalid for mode group
    input wire logic step_inc, // advance step counter
    input wire logic step_clr, // restart step counter
    input wire logic [4:0] fifo_fill_level, // bytes held in fifo
    input wire logic [7:0] offset_count, // outstanding sync offset
    input wire logic hs_req, // core wants a req or ack pulse
    output logic hs_ok, // pulse allowed this cycle
    output logic mcu_irq, // interrupt request to microcontroller
    output logic offset_not_full, // sync offset below maximum
    output logic [7:0] sel_timeout, // selection response timeout
    output logic [4:0] sync_period, // least req or ack gap
    output logic [7:0] sync_window, // sync offset value
    output logic [2:0] clock_factor_value, // clock conversion factor
    output logic [2:0] dest_id, // selection destination id
    output logic [7:0] setup_one, // setup register one
    output logic [7:0] setup_two, // setup register two
    output logic [7:0] setup_three, // setup register three
    output logic [7:0] setup_four // setup register four
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta_q;
    logic [NPIN-1:0] pin_sync_q;
    logic [NPIN-1:0] pin_last_q;
    assign pin_raw = {scsi_rst, scsi_atn, scsi_msg, scsi_cd, scsi_io};

    genvar gp;
    generate
        for (gp = 0; gp < NPIN; gp++) begin : g_pin
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    pin_meta_q[gp] <= 1'b0;
                    pin_sync_q[gp] <= 1'b0;
                    pin_last_q[gp] <= 1'b0;
                end else if (ce) begin
                    pin_meta_q[gp] <= pin_raw[gp];
                    pin_sync_q[gp] <= pin_meta_q[gp];
                    pin_last_q[gp] <= pin_sync_q[gp];
                end
            end
        end
    endgenerate

    logic atn_s;
    logic atn_rise;
    logic bus_rst_rise;
    assign atn_s = pin_sync_q[P_ATN];
    assign atn_rise = pin_sync_q[P_ATN] & ~pin_last_q[P_ATN];
    assign bus_rst_rise = pin_sync_q[P_RST] & ~pin_last_q[P_RST];

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] setup1_q, setup2_q, setup3_q, setup4_q;
    logic [7:0] timeout_q, window_q;
    logic [4:0] period_q;
    logic [2:0] clkf_q, dest_q, step_q;
    logic parity_check_on, bus_reset_irq_mask, ten_byte_group_two;
    assign parity_check_on = setup1_q[S1_PARITY_CHECK_ON];
    assign bus_reset_irq_mask = setup1_q[S1_SRD];
    assign ten_byte_group_two = setup3_q[S3_TEN_BYTE_GROUP_TWO];

    ////////////////////////////////////////////////////////////////////////////
    // event flags
    scr_flag_if fl ();
    scr_flag_bank u_bank (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .fl(fl)
    );

    logic grp_ok;
    always_comb begin
        case (cdb_group)
            GRP_SIX, GRP_TEN, GRP_TWELVE: grp_ok = 1'b1;
            GRP_TEN_TWO: grp_ok = ten_byte_group_two; // [R21]
            default: grp_ok = 1'b0;
        endcase
    end

    logic cause_rd;
    always_comb begin
        fl.set = '0;
        fl.set[F_TC] = ev_count_zero; // [R1]
        fl.set[F_PE] = ev_parity_err & parity_check_on; // [R2]
        fl.set[F_GE] = ev_gross_err; // [R3]
        fl.set[F_VGC] = cdb_valid & grp_ok; // [R6]
        fl.set[C_SEL] = ev_selected & ~atn_s; // [R7]
        fl.set[C_CHOSEN_WITH_ATTENTION] = ev_selected & atn_s; // [R7]
        fl.set[C_RECHOSEN_AS_INITIATOR] = ev_rechosen_as_initiator & ~target_mode; // [R8]
        fl.set[C_FC] = ev_cmd_done & target_mode; // [R9]
        fl.set[C_BS] = ev_service_req | (target_mode & atn_rise); // [R10]
        fl.set[C_DIS] = ev_seq_disc & target_mode; // [R11]
        fl.set[C_BAD_OPCODE] = opcode_wr & (opcode_reserved | opcode_mode_bad); // [R12]
        fl.set[C_BUS_RESET_SEEN] = bus_rst_rise; // [R13]
        // reading the cause register acknowledges the whole interrupt
        fl.clr = cause_rd ? '1 : '0;
    end

    logic [7:0] cause;
    logic [7:0] irq_mask;
    assign cause = fl.flags[C_BUS_RESET_SEEN:C_SEL];
    assign irq_mask = {~bus_reset_irq_mask, 7'h7f}; // [R20]
    // gross_fault lives outside the cause byte, so it cannot interrupt
    assign mcu_irq = |(cause & irq_mask); // [R3] [R4]

    ////////////////////////////////////////////////////////////////////////////
    // step counter
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            step_q <= 3'h0;
        end else if (ce) begin
            if (step_clr) begin
                step_q <= 3'h0;
            end else if (step_inc) begin
                step_q <= step_q + 3'h1; // [R15]
            end
        end
    end

    assign offset_not_full = offset_count < window_q; // [R16]

    ////////////////////////////////////////////////////////////////////////////
    // req/ack pacing, period zero means no limit
    logic [4:0] gap_q;
    logic [5:0] gap_next;
    assign gap_next = {1'b0, gap_q} + 6'h01;
    assign hs_ok = gap_next >= {1'b0, period_q}; // [R17]
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gap_q <= PERIOD_MAX;
        end else if (ce) begin
            if (hs_req && hs_ok) begin
                gap_q <= 5'h00; // [R17]
            end else if (gap_q != PERIOD_MAX) begin
                gap_q <= gap_next[4:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi write channel
    scr_wr_t wr_st_q, wr_st_d;
    logic [AXI_AW-1:0] awaddr_q, wa;
    logic [7:0] wdata_q, wd;
    logic wstrb_q, ws;
    logic aw_hs, w_hs, wr_fire, wr_hit;
    logic [1:0] bresp_q;
    assign s_axi_awready = ce & (wr_st_q == WR_IDLE || wr_st_q == WR_DATA);
    assign s_axi_wready = ce & (wr_st_q == WR_IDLE || wr_st_q == WR_ADDR);
    assign s_axi_bvalid = wr_st_q == WR_RESP;
    assign s_axi_bresp = bresp_q;
    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign wa = aw_hs ? s_axi_awaddr : awaddr_q;
    assign wd = w_hs ? s_axi_wdata[7:0] : wdata_q;
    assign ws = w_hs ? s_axi_wstrb[0] : wstrb_q;

    function automatic logic hit(input logic [AXI_AW-1:0] a, input logic [15:0] idx);
        hit = (a[AXI_AW-1:2] == idx) && (a[1:0] == 2'b00);
    endfunction : hit

    always_comb begin
        wr_st_d = wr_st_q;
        case (wr_st_q)
            WR_IDLE: begin
                if (aw_hs && w_hs) begin
                    wr_st_d = WR_RESP;
                end else if (aw_hs) begin
                    wr_st_d = WR_ADDR;
                end else if (w_hs) begin
                    wr_st_d = WR_DATA;
                end
            end
            WR_ADDR: if (w_hs) wr_st_d = WR_RESP;
            WR_DATA: if (aw_hs) wr_st_d = WR_RESP;
            WR_RESP: if (s_axi_bready) wr_st_d = WR_IDLE;
            default: wr_st_d = WR_IDLE;
        endcase
    end
    assign wr_fire = ce && wr_st_q != WR_RESP && wr_st_d == WR_RESP;
    assign wr_hit = hit(wa, IDX_STAT) | hit(wa, IDX_CAUSE) | hit(wa, IDX_STEP) | hit(wa, IDX_LEVEL)
        | hit(wa, IDX_SETUP1) | hit(wa, IDX_CLOCK) | hit(wa, IDX_SETUP2) | hit(wa, IDX_SETUP3)
        | hit(wa, IDX_SETUP4);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_st_q <= WR_IDLE;
            awaddr_q <= '0;
            wdata_q <= BYTE_RST;
            wstrb_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (ce) begin
            wr_st_q <= wr_st_d;
            if (aw_hs) awaddr_q <= s_axi_awaddr;
            if (w_hs) wdata_q <= s_axi_wdata[7:0];
            if (w_hs) wstrb_q <= s_axi_wstrb[0];
            if (wr_fire) bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            setup1_q <= BYTE_RST;
            setup2_q <= BYTE_RST;
            setup3_q <= BYTE_RST;
            setup4_q <= BYTE_RST;
            timeout_q <= BYTE_RST;
            window_q <= BYTE_RST;
            period_q <= 5'h00;
            clkf_q <= 3'h0;
            dest_q <= 3'h0;
        end else if (ce && wr_fire && ws) begin
            if (hit(wa, IDX_STAT)) dest_q <= wd[2:0];
            if (hit(wa, IDX_CAUSE)) timeout_q <= wd; // [R14]
            if (hit(wa, IDX_STEP)) period_q <= wd[4:0]; // [R17]
            if (hit(wa, IDX_LEVEL)) window_q <= wd; // [R19]
            if (hit(wa, IDX_SETUP1)) setup1_q <= wd;
            if (hit(wa, IDX_CLOCK)) clkf_q <= wd[2:0]; // [R22]
            if (hit(wa, IDX_SETUP2)) setup2_q <= wd;
            if (hit(wa, IDX_SETUP3)) setup3_q <= wd;
            if (hit(wa, IDX_SETUP4)) setup4_q <= {5'h00, wd[2:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi read channel
    logic ar_hs;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic [7:0] rdata_q;
    logic [1:0] rresp_q;
    logic rvalid_q;
    assign s_axi_arready = ce & ~rvalid_q;
    assign ar_hs = s_axi_arvalid & s_axi_arready;
    assign cause_rd = ar_hs && hit(s_axi_araddr, IDX_CAUSE);

    always_comb begin
        rd_byte = BYTE_RST;
        rd_hit = 1'b1;
        if (hit(s_axi_araddr, IDX_STAT)) begin
            rd_byte = {mcu_irq, fl.flags[F_GE], fl.flags[F_PE], fl.flags[F_TC], fl.flags[F_VGC],
                pin_sync_q[P_MSG], pin_sync_q[P_CD], pin_sync_q[P_IO]}; // [R4] [R5]
        end else if (hit(s_axi_araddr, IDX_CAUSE)) begin
            rd_byte = cause; // [R14]
        end else if (hit(s_axi_araddr, IDX_STEP)) begin
            rd_byte = {4'h0, offset_not_full, step_q}; // [R15] [R16]
        end else if (hit(s_axi_araddr, IDX_LEVEL)) begin
            rd_byte = {step_q, fifo_fill_level}; // [R18]
        end else if (hit(s_axi_araddr, IDX_SETUP1)) begin
            rd_byte = setup1_q;
        end else if (hit(s_axi_araddr, IDX_CLOCK)) begin
            rd_byte = BYTE_RST;
        end else if (hit(s_axi_araddr, IDX_SETUP2)) begin
            rd_byte = setup2_q;
        end else if (hit(s_axi_araddr, IDX_SETUP3)) begin
            rd_byte = setup3_q;
        end else if (hit(s_axi_araddr, IDX_SETUP4)) begin
            rd_byte = setup4_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= BYTE_RST;
            rresp_q <= RESP_OKAY;
        end else if (ce) begin
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_byte;
                rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = {24'h00_0000, rdata_q};
    assign s_axi_rresp = rresp_q;

    assign sel_timeout = timeout_q;
    assign sync_period = period_q;
    assign sync_window = window_q;
    assign clock_factor_value = clkf_q;
    assign dest_id = dest_q;
    assign setup_one = setup1_q;
    assign setup_two = setup2_q;
    assign setup_three = setup3_q;
    assign setup_four = setup4_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_tc;
        @(posedge sys_clk) disable iff (rst) (ce && ev_count_zero) |=> fl.flags[F_TC];
    endproperty
    a_tc: assert property (p_tc) else $error("count_expired not set"); // [R1]

    property p_pe;
        @(posedge sys_clk) disable iff (rst) $rose(fl.flags[F_PE]) |-> $past(ev_parity_err && parity_check_on);
    endproperty
    a_pe: assert property (p_pe) else $error("parity_fault set without checking"); // [R2]

    property p_ge;
        @(posedge sys_clk) disable iff (rst) (cause == 8'h00) |-> !mcu_irq;
    endproperty
    a_ge: assert property (p_ge) else $error("interrupt without a cause bit"); // [R3]

    property p_sel;
        @(posedge sys_clk) disable iff (rst)
        (ce && ev_selected) |=> ($past(atn_s) ? fl.flags[C_CHOSEN_WITH_ATTENTION] : fl.flags[C_SEL]);
    endproperty
    a_sel: assert property (p_sel) else $error("selection cause wrong"); // [R7]

    property p_fc;
        @(posedge sys_clk) disable iff (rst) (ce && ev_cmd_done && target_mode) |=> fl.flags[C_FC] ##0 mcu_irq;
    endproperty
    a_fc: assert property (p_fc) else $error("function_done not raised"); // [R9]

    property p_srd;
        @(posedge sys_clk) disable iff (rst) (cause == 8'h80 && bus_reset_irq_mask) |-> !mcu_irq;
    endproperty
    a_srd: assert property (p_srd) else $error("masked bus reset interrupted"); // [R20]

    property p_step;
        @(posedge sys_clk) disable iff (rst)
        (ce && step_inc && !step_clr) |=> step_q == $past(step_q) + 3'h1;
    endproperty
    a_step: assert property (p_step) else $error("step_counter did not advance"); // [R15]

    property p_pace;
        @(posedge sys_clk) disable iff (rst)
        (ce && hs_req && hs_ok && period_q == 5'h03) |=> !hs_ok ##1 !hs_ok;
    endproperty
    a_pace: assert property (p_pace) else $error("req or ack gap too short"); // [R17]

    property p_vgc;
        @(posedge sys_clk) disable iff (rst)
        (ce && cdb_valid && cdb_group == GRP_TEN_TWO && !ten_byte_group_two && !fl.flags[F_VGC])
            |=> !fl.flags[F_VGC];
    endproperty
    a_vgc: assert property (p_vgc) else $error("group two recognised while disabled"); // [R21]

    property p_bhold;
        @(posedge sys_clk) disable iff (rst) (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");

endmodule : scr_regs

// ---- scr_far.sv ----
// far side bus device model: drives the phase, attention and reset lines
`timescale 1ns/100ps
module scr_far #(parameter int DLY = 7) (
    input wire logic [4:0] cmd, // msg, c/d, i/o, atn, rst to show
    output logic [4:0] pins // bus lines as the block sees them
);
    assign #DLY pins = cmd;
endmodule : scr_far

// ---- tb_scsi_status_config_regs.sv ----
// self-checking bench for the scsi status and setup register bank
`timescale 1ns/100ps
module tb_scsi_status_config_regs import scr_pkg::*; ;
    logic sys_clk = 1'h0, rst = 1'h1, ce = 1'h1, target_mode = 1'h1, opcode_reserved = 1'h1;
    logic opcode_mode_bad = 1'h0, mcu_irq, offset_not_full, hs_ok;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [AXI_DW-1:0] s_axi_wdata = '0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp_seen;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [12:0] ev = '0;
    logic [4:0] far = '0, pins, fifo_fill_level = 5'h13, sync_period;
    logic [7:0] offset_count = 8'h04, sel_timeout, sync_window, setup_one, setup_two, setup_three, setup_four;
    logic [2:0] cdb_group = GRP_TEN_TWO, clock_factor_value, dest_id;
    int errors = 0, tests_run = 0;
    scr_regs i_dut (.*, .s_axi_wstrb(4'h1), .scsi_msg(pins[4]), .scsi_cd(pins[3]), .scsi_io(pins[2]),
        .scsi_atn(pins[1]), .scsi_rst(pins[0]), .ev_count_zero(ev[0]), .ev_parity_err(ev[1]),
        .ev_gross_err(ev[2]), .ev_selected(ev[3]), .ev_rechosen_as_initiator(ev[4]), .ev_cmd_done(ev[5]),
        .ev_service_req(ev[6]), .ev_seq_disc(ev[7]), .opcode_wr(ev[8]), .step_inc(ev[9]),
        .step_clr(ev[10]), .cdb_valid(ev[11]), .hs_req(ev[12]));
    scr_far i_far (.cmd(far), .pins(pins));
    always #25 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, exp, input string nm);
        tests_run++;
        if (seen !== exp) errors++;
        if (seen !== exp) $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    endtask : chk
    task automatic pulse(input int i);
        ev[i] <= 1'h1;
        @(posedge sys_clk);
        ev[i] <= 1'h0;
        @(posedge sys_clk);
    endtask : pulse
    // readies sampled mid-cycle, so each valid drops only after its own handshake
    task automatic bus(input logic w, input logic [15:0] ix, input logic [7:0] d, e);
        logic [2:0] rdy;
        logic [8:0] got;
        s_axi_awaddr <= {ix, 2'h0};
        s_axi_araddr <= {ix, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        do begin
            @(negedge sys_clk);
            rdy = {s_axi_awready, s_axi_wready, s_axi_arready};
            got = w ? {s_axi_bvalid, 6'h0, s_axi_bresp} : {s_axi_rvalid, s_axi_rdata[7:0]};
            rsp_seen = s_axi_rresp;
            @(posedge sys_clk);
            if (rdy[2] && w) s_axi_awvalid <= 1'h0;
            if (rdy[1] && w) s_axi_wvalid <= 1'h0;
            if (rdy[0] && !w) s_axi_arvalid <= 1'h0;
        end while (got[8] !== 1'h1);
        chk({8'h0, got[7:0]}, {8'h0, e}, "bus word");
    endtask : bus
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        bus(1'h1, IDX_CAUSE, 8'ha5, 8'h00);
        bus(1'h1, IDX_STEP, 8'hff, 8'h00);
        bus(1'h1, IDX_LEVEL, 8'h04, 8'h00);
        bus(1'h1, IDX_CLOCK, 8'h0e, 8'h00);
        bus(1'h1, 16'h0100, 8'h11, 8'h02);
        bus(1'h0, 16'h0100, 8'h00, 8'h00);
        chk({14'h0000, rsp_seen}, {14'h0000, RESP_SLVERR}, "read resp");
        chk({sel_timeout, sync_window}, 16'ha504, "timeout window");
        chk({8'h0, sync_period, clock_factor_value}, 16'h00fe, "period factor");
        far <= 5'h14;
        pulse(10);
        pulse(9);
        // clock enable low must freeze the step counter
        ce <= 1'h0;
        pulse(9);
        ce <= 1'h1;
        bus(1'h0, IDX_STEP, 8'h00, 8'h01);
        bus(1'h0, IDX_LEVEL, 8'h00, 8'h33);
        offset_count <= 8'h03;
        bus(1'h1, IDX_STAT, 8'h05, 8'h00);
        bus(1'h1, IDX_SETUP2, 8'h5a, 8'h00);
        bus(1'h1, IDX_SETUP4, 8'hff, 8'h00);
        bus(1'h0, IDX_SETUP4, 8'h00, 8'h07);
        chk({12'h000, dest_id, offset_not_full}, 16'h000b, "dest offset");
        chk({setup_two, setup_four}, 16'h5a07, "setup two four");
    endtask : t_regs
    // hs_ok is combinational, so it is looked at mid-cycle
    task automatic t_pace();
        bus(1'h1, IDX_STEP, 8'h03, 8'h00);
        pulse(12);
        @(negedge sys_clk);
        chk({15'h0000, hs_ok}, 16'h0000, "pace gap");
        @(negedge sys_clk);
        chk({15'h0000, hs_ok}, 16'h0001, "pace open");
        @(posedge sys_clk);
    endtask : t_pace
    task automatic t_events();
        far <= 5'h16;
        pulse(5);
        pulse(7);
        pulse(3);
        bus(1'h0, IDX_STAT, 8'h00, 8'h85);
        chk({15'h0000, mcu_irq}, 16'h0001, "irq pending");
        bus(1'h0, IDX_CAUSE, 8'h00, 8'h3a);
        target_mode <= 1'h0;
        pulse(4);
        pulse(5);
        pulse(6);
        pulse(8);
        bus(1'h0, IDX_CAUSE, 8'h00, 8'h54);
        pulse(2);
        pulse(1);
        pulse(0);
        pulse(11);
        bus(1'h0, IDX_STAT, 8'h00, 8'h55);
        far <= 5'h0d;
        bus(1'h1, IDX_SETUP1, 8'h50, 8'h00);
        bus(1'h1, IDX_SETUP3, 8'h20, 8'h00);
        pulse(1);
        pulse(11);
        bus(1'h0, IDX_STAT, 8'h00, 8'h7b);
        chk({15'h0000, mcu_irq}, 16'h0000, "irq masked");
        chk({setup_one, setup_three}, 16'h5020, "setup one three");
        opcode_reserved <= 1'h0;
        opcode_mode_bad <= 1'h1;
        pulse(8);
        pulse(3);
        bus(1'h0, IDX_CAUSE, 8'h00, 8'hc1);
    endtask : t_events
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'h0;
        t_regs();
        t_pace();
        t_events();
        tally_and_finish();
    end
    initial begin
        #200_000;
        errors++;
        tally_and_finish();
    end
endmodule : tb_scsi_status_config_regs
